// *** shared/msg_irq_map.svh ***
`ifndef MSG_IRQ_MAP_SVH
`define MSG_IRQ_MAP_SVH

// Inbound assertion register
`define APIC_BASE        32'hFEC0_0000
`define ASSERT_OFF       32'h0000_0020
`define MSG_NUM_W        5
`define IRQ_COUNT        24
`define IRQ_LAST         8'h23
`define IRQ_RSV_A        5'h00
`define IRQ_RSV_B        5'h02
`define IRQ_RSV_C        5'h08
`define IRQ_RSV_D        5'h0D
`define DECODE_WAIT      2'h2
`define ABORT_WAIT       3'h5

// Redirection entry fields
`define RTE_DEST_HI      63
`define RTE_DEST_LO      56
`define RTE_TRIG         15
`define RTE_DMODE_BIT    11
`define RTE_DLV_HI       10
`define RTE_DLV_LO       8
`define RTE_VEC_HI       7
`define RTE_VEC_LO       0

// Outbound message format
`define ADDR_TOP         12'hFEE
`define DLV_LOWEST       3'h1
`define DLV_SMI          3'h2
`define DLV_NMI          3'h4
`define DLV_INIT         3'h5

// Peer APB register map
`define PR_MSG_ADDR      12'h000
`define PR_MSG_DATA      12'h004
`define PR_CTRL          12'h008
`define PR_STATUS        12'h00C
`define PR_OUT_ADDR      12'h010
`define PR_OUT_DATA      12'h014
`define PR_OUT_COUNT     12'h018
`define ST_BUSY          0
`define ST_CLAIMED       1
`define ST_ABORTED       2
`define ST_CAPTURED      3

`endif

// *** shared/msg_irq_pkg.sv ***
`default_nettype none

package msg_irq_pkg;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_REQ    = 4'b0010,
		S_WRITE  = 4'b0100,
		S_SERIAL = 4'b1000
	} dev_state_t;

	typedef enum logic [2:0] {
		P_IDLE = 3'b001,
		P_SEND = 3'b010,
		P_WAIT = 3'b100
	} peer_state_t;

	typedef struct packed {
		logic [7:0] dest;
		logic       trig;
		logic       dst_mode;
		logic [2:0] dlv;
		logic [7:0] vec;
	} rte_t;

endpackage : msg_irq_pkg

`default_nettype wire

// *** shared/msg_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface msg_link_if;
	// Inbound write from a PCI master
	logic        in_valid;
	logic [31:0] in_addr;
	logic [31:0] in_data;
	logic        in_claim;
	// Outbound interrupt write
	logic        out_req;
	logic        out_gnt;
	logic        out_valid;
	logic [31:0] out_addr;
	logic [31:0] out_data;
	logic        out_ack;

	modport dev (
		input  in_valid, in_addr, in_data, out_gnt, out_ack,
		output in_claim, out_req, out_valid, out_addr, out_data
	);
	modport peer (
		output in_valid, in_addr, in_data, out_gnt, out_ack,
		input  in_claim, out_req, out_valid, out_addr, out_data
	);
endinterface : msg_link_if

`default_nettype wire

// *** design/apic_msg_dev.sv ***
// How it works
// - Message writes act only with APIC on
// - Assertion register sits at base plus 20h
// - Only low five data bits are used
// - Peripheral gets bus, writes its message
// - Claim writes at medium decode when capable
// - Set request bit for 00h-23h only; the code sets it for 00h-17h only, its 24 lines
// - Clear request after delivery, no software
// - Ignore messages naming 0, 2, 8, 13
// - Capability reads clear without extended enable
// - Memory writes need APIC on and select
// - Edge sets bit; level follows input
// - Request flushing bus grant before write
// - One assert message per rising edge
// - Level: assert on edge, again after END_OF_INTERRUPT
// - Each message is one 32-bit write
// - Address 19:12 carries destination ID
// - Address 11:4 and 1:0 are zero
// - Hint set only for lowest priority
// - Address bit 2 carries destination mode
// - SMI, NMI, INIT modes never sent
// - Data word field layout as specified
// - Status 1 for edge, input for level
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "msg_irq_map.svh"

module apic_msg_dev
	import msg_irq_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	msg_link_if.dev          LINK,
	input  wire logic        APIC_ON_IN,
	input  wire logic        EXTENDED_APIC_ON_IN,
	input  wire logic        WRITE_DELIVERY_SELECT_IN,
	input  wire logic        MSG_SUPPORT_IN,
	input  wire logic [23:0] IRQ_PINS_IN,
	input  wire logic        RTE_WE_IN,
	input  wire logic [4:0]  RTE_IDX_IN,
	input  wire logic [63:0] RTE_DATA_IN,
	input  wire logic        END_OF_INTERRUPT_IN,
	input  wire logic [4:0]  EOI_IDX_IN,
	input  wire logic        SERIAL_DONE_IN,
	output logic             PCI_MSG_CAPABLE_OUT,
	output logic [23:0]      IRQ_REQUEST_BIT_OUT,
	output logic             SERIAL_REQ_OUT,
	output logic [4:0]       SERIAL_IDX_OUT,
	output logic             BUSY_OUT
);

	localparam int N = `IRQ_COUNT;

	// Lowest pending line wins
	function automatic logic [4:0] pick(input logic [N-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : pick

	rte_t        rte_q [N];
	logic [N-1:0] pin_s1_q, pin_s2_q, pin_q;
	logic [N-1:0] irr_q, pend_q;
	logic [N-1:0] edge_trig, lvl_trig, rise, msg_set, eoi_hit, take;
	logic [1:0]  dec_cnt_q;
	logic        hit, claim, num_ok;
	logic [4:0]  num;
	dev_state_t  state_q;
	logic [4:0]  cur_q;
	logic [31:0] addr_q, data_q;
	rte_t        sel;
	logic        forbid, done;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			lvl_trig[i]  = rte_q[i].trig;
			edge_trig[i] = ~rte_q[i].trig;
		end
	end

	// Capability only advertised with extended enable
	assign PCI_MSG_CAPABLE_OUT = MSG_SUPPORT_IN & EXTENDED_APIC_ON_IN;

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			for (int i = 0; i < N; i++) begin
				rte_q[i] <= '0;
			end
		end else if (RTE_WE_IN && RTE_IDX_IN < 5'(N)) begin
			rte_q[RTE_IDX_IN] <= '{
				dest:     RTE_DATA_IN[`RTE_DEST_HI:`RTE_DEST_LO],
				trig:     RTE_DATA_IN[`RTE_TRIG],
				dst_mode: RTE_DATA_IN[`RTE_DMODE_BIT],
				dlv:      RTE_DATA_IN[`RTE_DLV_HI:`RTE_DLV_LO],
				vec:      RTE_DATA_IN[`RTE_VEC_HI:`RTE_VEC_LO]};
		end
	end

	// Pins are asynchronous to this clock
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_q    <= '0;
		end else begin
			pin_s1_q <= IRQ_PINS_IN;
			pin_s2_q <= pin_s1_q;
			pin_q    <= pin_s2_q;
		end
	end
	assign rise = pin_s2_q & ~pin_q;

	// Inbound decode, claim on third cycle of the request
	assign hit = LINK.in_valid
		&& LINK.in_addr == (`APIC_BASE + `ASSERT_OFF)
		&& PCI_MSG_CAPABLE_OUT;

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			dec_cnt_q <= 2'h0;
		end else if (!hit) begin
			dec_cnt_q <= 2'h0;
		end else if (dec_cnt_q != 2'h3) begin
			dec_cnt_q <= dec_cnt_q + 2'h1;
		end
	end
	assign claim = hit && dec_cnt_q == `DECODE_WAIT;
	assign LINK.in_claim = claim;

	assign num = LINK.in_data[`MSG_NUM_W-1:0];
	// Only 24 lines exist, so numbers past them are dropped too
	assign num_ok = {3'h0, num} <= `IRQ_LAST && num < 5'(N)
		&& num != `IRQ_RSV_A && num != `IRQ_RSV_B
		&& num != `IRQ_RSV_C && num != `IRQ_RSV_D;

	always_comb begin
		msg_set = '0;
		if (claim && APIC_ON_IN && num_ok) begin
			msg_set[num] = 1'b1;
		end
	end

	always_comb begin
		eoi_hit = '0;
		if (END_OF_INTERRUPT_IN && EOI_IDX_IN < 5'(N)) begin
			eoi_hit[EOI_IDX_IN] = 1'b1;
		end
	end

	assign sel = rte_q[cur_q];
	assign forbid = sel.dlv == `DLV_SMI || sel.dlv == `DLV_NMI
		|| sel.dlv == `DLV_INIT;
	assign done = (state_q == S_WRITE && LINK.out_ack)
		|| (state_q == S_SERIAL && SERIAL_DONE_IN)
		|| (state_q == S_REQ && forbid);

	always_comb begin
		take = '0;
		if (state_q == S_IDLE && APIC_ON_IN && |pend_q) begin
			take[pick(pend_q)] = 1'b1;
		end
	end

	// Request bits; a new edge beats the delivery clear
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			irr_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (lvl_trig[i]) begin
					irr_q[i] <= pin_s2_q[i];
				end else if (rise[i] || msg_set[i]) begin
					irr_q[i] <= 1'b1;
				end else if (done && cur_q == 5'(i)) begin
					irr_q[i] <= 1'b0;
				end
			end
		end
	end

	// Messages still owed to the processor
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~take)
				| rise
				| msg_set
				| (lvl_trig & eoi_hit & pin_s2_q);
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (|take) begin
						state_q <= S_REQ;
					end
				end
				S_REQ: begin
					if (forbid) begin
						state_q <= S_IDLE;
					end else if (!(APIC_ON_IN && WRITE_DELIVERY_SELECT_IN)) begin
						state_q <= S_SERIAL;
					end else if (LINK.out_gnt) begin
						state_q <= S_WRITE;
					end
				end
				S_WRITE: begin
					if (LINK.out_ack) begin
						state_q <= S_IDLE;
					end
				end
				S_SERIAL: begin
					if (SERIAL_DONE_IN) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			cur_q <= 5'h00;
		end else if (|take) begin
			cur_q <= pick(pend_q);
		end
	end

	// Word built while the grant is pending
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			addr_q <= 32'h0000_0000;
			data_q <= 32'h0000_0000;
		end else if (state_q == S_REQ) begin
			addr_q <= {`ADDR_TOP,
				sel.dest,
				8'h00,
				sel.dlv == `DLV_LOWEST,
				sel.dst_mode,
				2'h0};
			data_q <= {16'h0000,
				sel.trig,
				sel.trig ? pin_s2_q[cur_q] : 1'b1,
				2'h0,
				sel.dst_mode,
				sel.dlv,
				sel.vec};
		end
	end

	// Gate on both enables; select alone means nothing
	assign LINK.out_req = state_q == S_REQ && !forbid
		&& APIC_ON_IN && WRITE_DELIVERY_SELECT_IN;
	assign LINK.out_valid = state_q == S_WRITE;
	assign LINK.out_addr = addr_q;
	assign LINK.out_data = data_q;

	assign SERIAL_REQ_OUT = state_q == S_SERIAL;
	assign SERIAL_IDX_OUT = cur_q;
	assign IRQ_REQUEST_BIT_OUT = irr_q;
	assign BUSY_OUT = state_q != S_IDLE;

endmodule : apic_msg_dev

`default_nettype wire

// *** design/msg_peer_end.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "msg_irq_map.svh"

module msg_peer_end
	import msg_irq_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	msg_link_if.peer         LINK,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic [31:0]      PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT
);

	logic [31:0] maddr_q, mdata_q, oaddr_q, odata_q, ocount_q, rd;
	logic        claimed_q, aborted_q, captured_q, ack_q, gnt_q, mapped;
	logic [2:0]  wait_q;
	peer_state_t state_q;
	logic        wr, rdx, fire, cap;

	assign wr  = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign rdx = PSEL_IN && PENABLE_IN && !PWRITE_IN;
	assign fire = wr && PADDR_IN == `PR_CTRL && PWDATA_IN[0]
		&& state_q == P_IDLE;
	assign cap = LINK.out_valid && !ack_q;

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			maddr_q <= `APIC_BASE + `ASSERT_OFF;
			mdata_q <= 32'h0000_0000;
		end else if (wr && PADDR_IN == `PR_MSG_ADDR) begin
			maddr_q <= PWDATA_IN;
		end else if (wr && PADDR_IN == `PR_MSG_DATA) begin
			mdata_q <= PWDATA_IN;
		end
	end

	// Raise the message as a bus master write
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			state_q <= P_IDLE;
			wait_q  <= 3'h0;
		end else begin
			unique case (state_q)
				P_IDLE: begin
					wait_q <= 3'h0;
					if (fire) begin
						state_q <= P_SEND;
					end
				end
				P_SEND: begin
					wait_q <= wait_q + 3'h1;
					if (LINK.in_claim || wait_q == `ABORT_WAIT) begin
						state_q <= P_WAIT;
					end
				end
				P_WAIT: begin
					state_q <= P_IDLE;
				end
			endcase
		end
	end

	// Sticky status; claimed and aborted clear on a new send, captured set beats its write-one clear
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			claimed_q  <= 1'b0;
			aborted_q  <= 1'b0;
			captured_q <= 1'b0;
		end else begin
			if (state_q == P_SEND && LINK.in_claim) begin
				claimed_q <= 1'b1;
			end else if (fire) begin
				claimed_q <= 1'b0;
			end
			if (state_q == P_SEND && !LINK.in_claim && wait_q == `ABORT_WAIT) begin
				aborted_q <= 1'b1;
			end else if (fire) begin
				aborted_q <= 1'b0;
			end
			if (cap) begin
				captured_q <= 1'b1;
			end else if (wr && PADDR_IN == `PR_STATUS && PWDATA_IN[`ST_CAPTURED]) begin
				captured_q <= 1'b0;
			end
		end
	end

	assign LINK.in_valid = state_q == P_SEND;
	assign LINK.in_addr  = maddr_q;
	assign LINK.in_data  = mdata_q;

	// Host bridge: grant a cycle later, ack each word once
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			gnt_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			gnt_q <= LINK.out_req;
			ack_q <= cap;
		end
	end
	assign LINK.out_gnt = gnt_q;
	assign LINK.out_ack = ack_q;

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			oaddr_q  <= 32'h0000_0000;
			odata_q  <= 32'h0000_0000;
			ocount_q <= 32'h0000_0000;
		end else if (cap) begin
			oaddr_q  <= LINK.out_addr;
			odata_q  <= LINK.out_data;
			ocount_q <= ocount_q + 32'h0000_0001;
		end
	end

	always_comb begin
		mapped = 1'b1;
		rd = 32'h0000_0000;
		unique case (PADDR_IN)
			`PR_MSG_ADDR:  rd = maddr_q;
			`PR_MSG_DATA:  rd = mdata_q;
			`PR_CTRL:      rd = 32'h0000_0000;
			`PR_STATUS:    rd = {28'h0, captured_q, aborted_q, claimed_q,
				state_q != P_IDLE};
			`PR_OUT_ADDR:  rd = oaddr_q;
			`PR_OUT_DATA:  rd = odata_q;
			`PR_OUT_COUNT: rd = ocount_q;
			default:       mapped = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			PRDATA_OUT <= rd;
		end
	end

	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

	logic unused_rdx;
	assign unused_rdx = rdx;

endmodule : msg_peer_end

`default_nettype wire

// *** test/apic_msg_properties.sv ***
`timescale 1ns/1ns
`default_nettype none

module apic_msg_properties (
	input wire logic        REF_CLK_IN,
	input wire logic        RST_B_IN,
	input wire logic        in_valid,
	input wire logic [31:0] in_addr,
	input wire logic        in_claim,
	input wire logic        out_req,
	input wire logic        out_gnt,
	input wire logic        out_valid,
	input wire logic [31:0] out_addr,
	input wire logic [31:0] out_data,
	input wire logic        out_ack
);
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	sequence s_grant;
		$rose(out_req) ##1 out_gnt;
	endsequence

	chk_grant_first: assert property (s_grant |=> out_valid)
		else $error("write did not follow grant");
	chk_gnt_before: assert property ($rose(out_valid) |-> $past(out_gnt))
		else $error("write without grant");
	chk_write_holds: assert property (out_valid && !out_ack |=>
		out_valid && $stable(out_addr) && $stable(out_data))
		else $error("write changed before ack");
	chk_one_write: assert property (out_valid && out_ack |=> !out_valid)
		else $error("write outlived ack");
	chk_addr_top: assert property (out_valid |-> out_addr[31:20] == 12'hFEE)
		else $error("address top wrong");
	chk_addr_zero: assert property (out_valid |->
		out_addr[11:4] == 8'h00 && out_addr[1:0] == 2'h0)
		else $error("address reserved bits set");
	chk_hint_lowest: assert property (out_valid |->
		out_addr[3] == (out_data[10:8] == 3'h1))
		else $error("redirection hint wrong");
	chk_dest_mode: assert property (out_valid |-> out_addr[2] == out_data[11])
		else $error("destination mode wrong");
	chk_data_zero: assert property (out_valid |->
		out_data[31:16] == 16'h0000 && out_data[13:12] == 2'h0)
		else $error("data reserved bits set");
	chk_no_pin_modes: assert property (out_valid |->
		!(out_data[10:8] inside {3'h2, 3'h4, 3'h5}))
		else $error("pin-only mode sent");
	chk_edge_status: assert property (out_valid && !out_data[15] |-> out_data[14])
		else $error("edge status not assert");
	chk_claim_medium: assert property (in_claim |-> in_valid &&
		$past(in_valid) && $past(in_valid, 2) && !$past(in_valid, 3) &&
		in_addr == 32'hFEC0_0020)
		else $error("claim timing or address wrong");
endmodule : apic_msg_properties

`default_nettype wire

// *** test/test_apic_message_interrupt_delivery.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "msg_irq_map.svh"

module test_apic_message_interrupt_delivery import msg_irq_pkg::*;;
	localparam logic [31:0] MA = 32'hFEC0_0020;
	logic        clk, rst_b, apic_on, ext_on, sel, sup, rte_we, end_of_interrupt, sdone;
	logic        psel, penable, pwrite, pready, perr, er, cap, sreq, busy;
	logic [23:0] pins, irq_request_bit;
	logic [4:0]  rte_idx, eoi_idx, sidx;
	logic [63:0] rte_data;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          errors = 0;
	int          num_checks = 0;
	logic [55:0] rows [8] = '{{32'hFFFF_FF05, 24'h000020},
		{32'h17, 24'h800000}, {32'h0, 24'h0}, {32'h2, 24'h0},
		{32'h8, 24'h0}, {32'hD, 24'h0}, {32'h18, 24'h0}, {32'h23, 24'h000008}};

	msg_link_if link ();
	apic_msg_dev apic_msg_dev_inst (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
		.LINK(link), .APIC_ON_IN(apic_on), .EXTENDED_APIC_ON_IN(ext_on),
		.WRITE_DELIVERY_SELECT_IN(sel), .MSG_SUPPORT_IN(sup),
		.IRQ_PINS_IN(pins), .RTE_WE_IN(rte_we), .RTE_IDX_IN(rte_idx),
		.RTE_DATA_IN(rte_data), .END_OF_INTERRUPT_IN(end_of_interrupt),
		.EOI_IDX_IN(eoi_idx), .SERIAL_DONE_IN(sdone),
		.PCI_MSG_CAPABLE_OUT(cap), .IRQ_REQUEST_BIT_OUT(irq_request_bit),
		.SERIAL_REQ_OUT(sreq), .SERIAL_IDX_OUT(sidx), .BUSY_OUT(busy));
	msg_peer_end msg_peer_end_inst (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
		.LINK(link), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr));
	apic_msg_properties apic_msg_properties_inst (.REF_CLK_IN(clk),
		.RST_B_IN(rst_b), .in_valid(link.in_valid), .in_addr(link.in_addr),
		.in_claim(link.in_claim), .out_req(link.out_req),
		.out_gnt(link.out_gnt), .out_valid(link.out_valid),
		.out_addr(link.out_addr), .out_data(link.out_data),
		.out_ack(link.out_ack));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Leading edge keeps release and next setup in separate steps
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			errors++;
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic msg(input logic [31:0] a, d);
		int n;
		n = 0;
		apb(1'b1, `PR_MSG_ADDR, a);
		apb(1'b1, `PR_MSG_DATA, d);
		apb(1'b1, `PR_CTRL, 32'h1);
		do begin
			apb(1'b0, `PR_STATUS, '0);
			n++;
		end while (rd[`ST_BUSY] !== 1'b0 && n < 20);
		if (rd[`ST_BUSY] !== 1'b0)
			errors++;
		repeat (2) @(posedge clk);
	endtask : msg

	task automatic rte(input logic [4:0] i, input logic [63:0] d);
		rte_idx <= i;
		rte_data <= d;
		rte_we <= 1'b1;
		@(posedge clk);
		rte_we <= 1'b0;
	endtask : rte

	task automatic outchk(input logic [31:0] a, d, c);
		repeat (15) @(posedge clk);
		apb(1'b0, `PR_OUT_ADDR, '0);
		chk("out address", a, rd);
		apb(1'b0, `PR_OUT_DATA, '0);
		chk("out data", d, rd);
		apb(1'b0, `PR_OUT_COUNT, '0);
		chk("out count", c, rd);
	endtask : outchk

	initial begin
		{rst_b, sel, rte_we, end_of_interrupt, sdone, psel, penable, pwrite} = '0;
		{apic_on, ext_on, sup} = '1;
		{pins, rte_idx, eoi_idx, rte_data, paddr, pwdata} = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, `PR_MSG_ADDR, '0);
		chk("reset address", MA, rd);
		chk("reset busy", '0, {irq_request_bit, busy});
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			msg(MA, rows[i][55:24]);
			chk("claimed", 32'h1, rd[`ST_CLAIMED]);
			chk("request", rows[i][23:0], irq_request_bit);
			if (|rows[i][23:0]) begin
				chk("serial index", {27'h0, rows[i][28:24]}, sidx);
				chk("serial request", 32'h1, sreq);
			end
			sdone <= 1'b1;
			repeat (2) @(posedge clk);
			sdone <= 1'b0;
			repeat (3) @(posedge clk);
			chk("cleared", '0, irq_request_bit);
		end
		$display("inbound table done");
		apic_on <= 1'b0;
		msg(MA, 32'h5);
		chk("apic off", '0, irq_request_bit);
		{apic_on, ext_on} <= 2'b10;
		@(posedge clk);
		chk("capable", '0, cap);
		msg(MA, 32'h5);
		chk("aborted", 32'h1, rd[`ST_ABORTED]);
		ext_on <= 1'b1;
		msg(MA + 32'h4, 32'h5);
		chk("bad address", 32'h1, rd[`ST_ABORTED]);
		apb(1'b0, 12'h020, '0);
		chk("unmapped", 32'h1, er);
		$display("inbound refusal done");
		sel <= 1'b1;
		rte(5'd3, {8'hA5, 40'h0, 4'h0, 1'b1, 3'h1, 8'h5A});
		pins[3] <= 1'b1;
		outchk(32'hFEEA_500C, 32'h495A, 32'h1);
		outchk(32'hFEEA_500C, 32'h495A, 32'h1);
		pins[3] <= 1'b0;
		repeat (6) @(posedge clk);
		pins[3] <= 1'b1;
		outchk(32'hFEEA_500C, 32'h495A, 32'h2);
		rte(5'd4, {8'h3C, 40'h0, 4'h8, 1'b0, 3'h0, 8'h21});
		pins[4] <= 1'b1;
		outchk(32'hFEE3_C000, 32'hC021, 32'h3);
		chk("level request", 32'h1, irq_request_bit[4]);
		eoi_idx <= 5'd4;
		end_of_interrupt <= 1'b1;
		@(posedge clk);
		end_of_interrupt <= 1'b0;
		outchk(32'hFEE3_C000, 32'hC021, 32'h4);
		pins[4] <= 1'b0;
		repeat (6) @(posedge clk);
		chk("level drop", '0, irq_request_bit[4]);
		foreach (rows[i]) if (i inside {2, 4, 5}) begin
			rte(5'd6, {48'h0, 5'h0, i[2:0], 8'h33});
			pins[6] <= 1'b1;
			outchk(32'hFEE3_C000, 32'hC021, 32'h4);
			pins[6] <= 1'b0;
		end
		chk("dropped request", '0, irq_request_bit[6]);
		{apic_on, pins[3]} <= 2'b00;
		repeat (6) @(posedge clk);
		pins[3] <= 1'b1;
		outchk(32'hFEE3_C000, 32'hC021, 32'h4);
		chk("serial idle", '0, sreq);
		$display("outbound test done");
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up();
	end
endmodule : test_apic_message_interrupt_delivery

`default_nettype wire
